// ===== rtl/lbidc_config.sv
`timescale 1ns/10ps
`default_nettype none
module lbidc_config #(
	parameter int DT_TIMEOUT_CYCLES = lbidc_pkg::DT_TIMEOUT_CYCLES
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// configuration cycles
	input wire logic cfg_wr_en,
	input wire logic cfg_rd_en,
	input wire logic [7:0] cfg_addr,
	input wire logic [3:0] cfg_byte_en,
	input wire logic [31:0] cfg_wdata,
	output logic [31:0] cfg_rdata,
	output logic cfg_rd_valid,
	// error sources
	input wire logic global_syserr_enable,
	input wire logic target_abort_evt,
	input wire logic dt_complete,
	input wire logic dt_master_return,
	output logic syserr_assert,
	output logic dt_discard,
	// gpio window
	input wire logic io_cycle,
	input wire logic [15:0] io_addr,
	output logic gpio_decode_hit,
	output logic gpio_function_enable,
	// interrupt steering
	input wire logic [7:0] irq_line_in,
	output logic [15:0] legacy_irq,
	// serial irq pin
	input wire logic serial_irq_pin_in,
	output logic serial_irq_pin_out,
	output logic serial_irq_pin_oe,
	output logic [31:0] serial_irq_slots,
	// dma channel types
	output logic [15:0] dma_channel_type
);
	localparam int CW = $clog2(DT_TIMEOUT_CYCLES + 1);
	localparam logic [CW-1:0] DT_LAST = CW'(DT_TIMEOUT_CYCLES - 1);

	typedef struct packed {
		logic [31:0] gpio_base;
		logic [7:0] gpio_ctrl;
		logic [31:0] route_ad;
		logic [7:0] sirq_ctrl;
		logic [31:0] route_eh;
		logic [7:0] err_cfg;
		logic [7:0] err_sts;
		logic [15:0] dma_sel;
		logic [31:0] rdata;
		logic rd_valid;
		logic syserr;
		logic dt_active;
		logic [CW-1:0] dt_count;
		logic dt_discard;
		logic gpio_hit;
		logic [15:0] legacy;
	} lbidc_cfg_regs_type;

	lbidc_cfg_regs_type s;
	lbidc_cfg_regs_type next_s;
	logic [7:0] dword;
	logic [63:0] route_all;
	logic [7:0][15:0] route_hot;
	logic [15:0] legacy_comb;
	logic [7:0] sts_clear;
	logic rta_rise;
	logic dtt_evt;
	logic dtt_rise;

	// ****************************************
	// byte-lane merge
	// ****************************************
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be, input logic [31:0] mask);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				res[i*8 +: 8] = (wd[i*8 +: 8] & mask[i*8 +: 8]) | (old[i*8 +: 8] & ~mask[i*8 +: 8]);
			end
		end
		return res;
	endfunction

	// ****************************************
	// interrupt line steering
	// ****************************************
	assign route_all = {s.route_eh, s.route_ad};

	generate
		for (genvar g = 0; g < 8; g++) begin : g_line
			lbidc_route_decode u_dec (
				.code(route_all[g*8 +: 4]),
				.irq_onehot(route_hot[g])
			);
		end
	endgenerate

	always_comb begin
		legacy_comb = 16'h0000;
		for (int i = 0; i < 8; i++) begin
			if (!route_all[i*8 + lbidc_pkg::ROUTE_DIS_BIT] && irq_line_in[i]) begin
				legacy_comb = legacy_comb | route_hot[i];
			end
		end
	end

	// ****************************************
	// serial irq machine
	// ****************************************
	lbidc_serial_irq u_sirq (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.enable(s.sirq_ctrl[lbidc_pkg::SIRQ_EN_BIT]),
		.continuous(s.sirq_ctrl[lbidc_pkg::SIRQ_MODE_BIT]),
		.frame_size(s.sirq_ctrl[lbidc_pkg::SIRQ_SIZE_LSB +: 4]),
		.pulse_sel(s.sirq_ctrl[lbidc_pkg::SIRQ_PW_LSB +: 2]),
		.pin_in(serial_irq_pin_in),
		.pin_out(serial_irq_pin_out),
		.pin_oe(serial_irq_pin_oe),
		.slots(serial_irq_slots)
	);

	// ****************************************
	// register file and error logic
	// ****************************************
	always_comb begin
		dword = {cfg_addr[7:2], 2'b00};
		next_s = s;
		next_s.rd_valid = cfg_rd_en;
		sts_clear = 8'h00;
		if (cfg_wr_en) begin
			case (dword)
				lbidc_pkg::OFS_GPIO_BASE:
					next_s.gpio_base = merge(s.gpio_base, cfg_wdata, cfg_byte_en, lbidc_pkg::WMASK_GPIO_BASE);
				lbidc_pkg::OFS_GPIO_CTRL:
					next_s.gpio_ctrl = 8'(merge({24'h0, s.gpio_ctrl}, cfg_wdata, cfg_byte_en,
						lbidc_pkg::WMASK_GPIO_CTRL));
				lbidc_pkg::OFS_ROUTE_AD:
					next_s.route_ad = merge(s.route_ad, cfg_wdata, cfg_byte_en, lbidc_pkg::WMASK_ROUTE);
				lbidc_pkg::OFS_SIRQ_CTRL:
					next_s.sirq_ctrl = 8'(merge({24'h0, s.sirq_ctrl}, cfg_wdata, cfg_byte_en,
						lbidc_pkg::WMASK_SIRQ_CTRL));
				lbidc_pkg::OFS_ROUTE_EH:
					next_s.route_eh = merge(s.route_eh, cfg_wdata, cfg_byte_en, lbidc_pkg::WMASK_ROUTE);
				lbidc_pkg::OFS_ERR_CFG: begin
					next_s.err_cfg = 8'(merge({24'h0, s.err_cfg}, cfg_wdata, cfg_byte_en,
						lbidc_pkg::WMASK_ERR_CFG));
					if (cfg_byte_en[lbidc_pkg::OFS_ERR_STS[1:0]]) begin
						sts_clear = cfg_wdata[8*lbidc_pkg::OFS_ERR_STS[1:0] +: 8];
					end
				end
				lbidc_pkg::OFS_DMA_SEL:
					next_s.dma_sel = 16'(merge({16'h0, s.dma_sel}, cfg_wdata, cfg_byte_en,
						lbidc_pkg::WMASK_DMA_SEL));
				default: ;
			endcase
		end
		if (cfg_rd_en) begin
			case (dword)
				lbidc_pkg::OFS_GPIO_BASE: next_s.rdata = s.gpio_base;
				lbidc_pkg::OFS_GPIO_CTRL: next_s.rdata = {24'h0, s.gpio_ctrl};
				lbidc_pkg::OFS_ROUTE_AD: next_s.rdata = s.route_ad;
				lbidc_pkg::OFS_SIRQ_CTRL: next_s.rdata = {24'h0, s.sirq_ctrl};
				lbidc_pkg::OFS_ROUTE_EH: next_s.rdata = s.route_eh;
				lbidc_pkg::OFS_ERR_CFG: next_s.rdata = {8'h0, s.err_sts, 8'h0, s.err_cfg};
				lbidc_pkg::OFS_DMA_SEL: next_s.rdata = {16'h0, s.dma_sel};
				default: next_s.rdata = 32'h0;
			endcase
		end
		// delayed transaction watchdog
		dtt_evt = 1'b0;
		next_s.dt_discard = 1'b0;
		if (dt_complete) begin
			next_s.dt_active = 1'b1;
			next_s.dt_count = '0;
		end else if (s.dt_active) begin
			if (dt_master_return) begin
				next_s.dt_active = 1'b0;
			end else if (s.dt_count == DT_LAST) begin
				next_s.dt_active = 1'b0;
				next_s.dt_discard = 1'b1;
				dtt_evt = 1'b1;
			end else begin
				next_s.dt_count = s.dt_count + CW'(1);
			end
		end
		// set wins over a simultaneous write-one clear
		next_s.err_sts = s.err_sts & ~(sts_clear & 8'h06);
		if (target_abort_evt) begin
			next_s.err_sts[lbidc_pkg::ERR_RTA_BIT] = 1'b1;
		end
		if (dtt_evt) begin
			next_s.err_sts[lbidc_pkg::ERR_DTT_BIT] = 1'b1;
		end
		rta_rise = target_abort_evt && !s.err_sts[lbidc_pkg::ERR_RTA_BIT];
		dtt_rise = dtt_evt && !s.err_sts[lbidc_pkg::ERR_DTT_BIT];
		next_s.syserr = global_syserr_enable
			&& ((rta_rise && s.err_cfg[lbidc_pkg::ERR_RTA_BIT])
			|| (dtt_rise && s.err_cfg[lbidc_pkg::ERR_DTT_BIT]));
		next_s.gpio_hit = io_cycle && s.gpio_ctrl[lbidc_pkg::GPIO_EN_BIT]
			&& (io_addr[15:6] == s.gpio_base[lbidc_pkg::GPIO_BASE_MSB:lbidc_pkg::GPIO_BASE_LSB]);
		next_s.legacy = legacy_comb;
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			s <= '0;
			s.gpio_base <= lbidc_pkg::RST_GPIO_BASE;
			s.gpio_ctrl <= lbidc_pkg::RST_GPIO_CTRL;
			s.route_ad <= lbidc_pkg::RST_ROUTE;
			s.sirq_ctrl <= lbidc_pkg::RST_SIRQ_CTRL;
			s.route_eh <= lbidc_pkg::RST_ROUTE;
			s.err_cfg <= lbidc_pkg::RST_ERR_CFG;
			s.err_sts <= lbidc_pkg::RST_ERR_STS;
			s.dma_sel <= lbidc_pkg::RST_DMA_SEL;
		end else begin
			s <= next_s;
		end
	end

	assign cfg_rdata = s.rdata;
	assign cfg_rd_valid = s.rd_valid;
	assign syserr_assert = s.syserr;
	assign dt_discard = s.dt_discard;
	assign gpio_decode_hit = s.gpio_hit;
	assign gpio_function_enable = s.gpio_ctrl[lbidc_pkg::GPIO_EN_BIT];
	assign legacy_irq = s.legacy;
	assign dma_channel_type = s.dma_sel;

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	chk_base_io_bit: assert property (
		cfg_rd_en && ({cfg_addr[7:2], 2'b00} == lbidc_pkg::OFS_GPIO_BASE)
		|=> cfg_rd_valid && cfg_rdata[0] && (cfg_rdata[31:16] == 16'h0) && (cfg_rdata[5:1] == 5'h0))
		else $error("gpio base read shows wrong fixed bits");
	chk_gpio_gate: assert property (
		gpio_decode_hit |-> $past(s.gpio_ctrl[lbidc_pkg::GPIO_EN_BIT]) && $past(io_cycle))
		else $error("gpio window decoded while disabled");
	chk_route_off: assert property (
		(s.route_ad[7] && s.route_ad[15] && s.route_ad[23] && s.route_ad[31]
		&& s.route_eh[7] && s.route_eh[15] && s.route_eh[23] && s.route_eh[31]) [*2]
		|-> legacy_irq == 16'h0)
		else $error("disabled line reached legacy irq");
	chk_route_code: assert property (
		(irq_line_in == 8'h01) && (s.route_ad[7:0] == 8'h0d) |=> legacy_irq == 16'h0)
		else $error("reserved route code selected an irq");
	chk_sirq_off: assert property (
		!s.sirq_ctrl[lbidc_pkg::SIRQ_EN_BIT] [*2] |-> !serial_irq_pin_oe && (serial_irq_slots == 32'hffffffff))
		else $error("serial irq active while disabled");
	chk_syserr_gate: assert property (
		syserr_assert |-> $past(global_syserr_enable))
		else $error("syserr without global enable");
	chk_abort_syserr: assert property (
		target_abort_evt && !s.err_sts[2] && s.err_cfg[2] && global_syserr_enable |=> syserr_assert)
		else $error("target abort failed to raise syserr");
	chk_abort_status: assert property (
		target_abort_evt |=> s.err_sts[lbidc_pkg::ERR_RTA_BIT])
		else $error("target abort status not set");
	chk_w1c_clear: assert property (
		cfg_wr_en && ({cfg_addr[7:2], 2'b00} == lbidc_pkg::OFS_ERR_CFG) && cfg_byte_en[2] && cfg_wdata[18]
		&& !target_abort_evt |=> !s.err_sts[lbidc_pkg::ERR_RTA_BIT])
		else $error("write one did not clear abort status");
	chk_dt_discard: assert property (
		dt_discard |-> $past(s.dt_active) && ($past(s.dt_count) == DT_LAST) ##1 s.err_sts[1])
		else $error("delayed timeout discard at wrong time");
	chk_reserved_zero: assert property (
		(s.err_cfg[7:3] == 5'h0) && !s.err_cfg[0] && (s.dma_sel[9:8] == 2'h0) && (s.err_sts[7:3] == 5'h0)
		&& !s.err_sts[0] && (s.gpio_base[31:16] == 16'h0) && (s.gpio_base[5:0] == 6'h01)
		&& ((s.gpio_ctrl & 8'hef) == 8'h00) && ((s.route_ad & 32'h7070_7070) == 32'h0)
		&& ((s.route_eh & 32'h7070_7070) == 32'h0))
		else $error("reserved bits became nonzero");
	chk_gpio_addr: assert property (
		gpio_decode_hit |-> ($past(io_addr[15:6]) == $past(s.gpio_base[15:6])))
		else $error("gpio hit outside the window");
	chk_gpio_off: assert property (
		!s.gpio_ctrl[lbidc_pkg::GPIO_EN_BIT] |=> !gpio_decode_hit)
		else $error("gpio hit while disabled");
	chk_route_idle: assert property (
		(irq_line_in == 8'h00) |=> (legacy_irq == 16'h0))
		else $error("legacy irq without a request");
	chk_legacy_valid: assert property (
		(legacy_irq & 16'h2107) == 16'h0)
		else $error("reserved legacy irq raised");
	chk_rd_zero: assert property (
		cfg_rd_en && (cfg_addr[7:2] == 6'h1c) |=> (cfg_rdata == 32'h0))
		else $error("unmapped dword read nonzero");

	// ****************************************
	// error path checks
	// ****************************************
	chk_syserr_cause: assert property (
		syserr_assert |-> $past(target_abort_evt) || dt_discard)
		else $error("syserr without an error event");
	chk_dtt_syserr: assert property (
		s.dt_active && !dt_complete && !dt_master_return && (s.dt_count == DT_LAST) && !s.err_sts[1]
		&& s.err_cfg[1] && global_syserr_enable |=> syserr_assert)
		else $error("delayed timeout failed to raise syserr");
	chk_dtt_status: assert property (
		dt_discard |-> s.err_sts[lbidc_pkg::ERR_DTT_BIT])
		else $error("discard without timeout status");
	chk_dt_count_range: assert property (
		s.dt_active |-> (s.dt_count <= DT_LAST))
		else $error("watchdog count past its limit");

	// ****************************************
	// serial irq checks
	// ****************************************
	chk_sirq_width_4: assert property (
		$rose(serial_irq_pin_oe) && $past(serial_irq_pin_oe, 2) && (s.sirq_ctrl[7:6] == 2'b11)
		&& (s.sirq_ctrl[1:0] == 2'b00) && (s.sirq_ctrl == $past(s.sirq_ctrl))
		&& (s.sirq_ctrl == $past(s.sirq_ctrl, 2)) |-> serial_irq_pin_oe [*4] ##1 !serial_irq_pin_oe)
		else $error("start pulse not 4 clocks");
	chk_sirq_width_6: assert property (
		$rose(serial_irq_pin_oe) && $past(serial_irq_pin_oe, 2) && (s.sirq_ctrl[7:6] == 2'b11)
		&& (s.sirq_ctrl[1:0] == 2'b01) && (s.sirq_ctrl == $past(s.sirq_ctrl))
		&& (s.sirq_ctrl == $past(s.sirq_ctrl, 2)) |-> serial_irq_pin_oe [*6] ##1 !serial_irq_pin_oe)
		else $error("start pulse not 6 clocks");
	chk_sirq_width_8: assert property (
		$rose(serial_irq_pin_oe) && $past(serial_irq_pin_oe, 2) && (s.sirq_ctrl[7:6] == 2'b11)
		&& (s.sirq_ctrl[1:0] == 2'b10) && (s.sirq_ctrl == $past(s.sirq_ctrl))
		&& (s.sirq_ctrl == $past(s.sirq_ctrl, 2)) |-> serial_irq_pin_oe [*8] ##1 !serial_irq_pin_oe)
		else $error("start pulse not 8 clocks");
	chk_quiet_start: assert property (
		$rose(serial_irq_pin_oe) && $past(!serial_irq_pin_in) && (s.sirq_ctrl[7:6] == 2'b10)
		&& (s.sirq_ctrl[1:0] == 2'b00) && (s.sirq_ctrl == $past(s.sirq_ctrl))
		|-> serial_irq_pin_oe [*3] ##1 !serial_irq_pin_oe)
		else $error("quiet start pulse not 3 clocks");

	cov_syserr: cover property (syserr_assert);
	cov_discard: cover property (dt_discard);
	cov_sirq_drive: cover property (serial_irq_pin_oe);
	cov_route: cover property (legacy_irq != 16'h0);
	cov_quiet_start: cover property ($rose(serial_irq_pin_oe) && !s.sirq_ctrl[lbidc_pkg::SIRQ_MODE_BIT]);
endmodule
`default_nettype wire

// ===== rtl/lbidc_pkg.sv
package lbidc_pkg;
	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] OFS_GPIO_BASE = 8'h58;
	localparam logic [7:0] OFS_GPIO_CTRL = 8'h5c;
	localparam logic [7:0] OFS_ROUTE_AD = 8'h60;
	localparam logic [7:0] OFS_SIRQ_CTRL = 8'h64;
	localparam logic [7:0] OFS_ROUTE_EH = 8'h68;
	localparam logic [7:0] OFS_ERR_CFG = 8'h88;
	localparam logic [7:0] OFS_ERR_STS = 8'h8a;
	localparam logic [7:0] OFS_DMA_SEL = 8'h90;

	// ****************************************
	// field positions
	// ****************************************
	localparam int GPIO_BASE_LSB = 6;
	localparam int GPIO_BASE_MSB = 15;
	localparam int GPIO_EN_BIT = 4;
	localparam int ROUTE_DIS_BIT = 7;
	localparam int SIRQ_EN_BIT = 7;
	localparam int SIRQ_MODE_BIT = 6;
	localparam int SIRQ_SIZE_LSB = 2;
	localparam int SIRQ_PW_LSB = 0;
	localparam int ERR_RTA_BIT = 2;
	localparam int ERR_DTT_BIT = 1;

	// ****************************************
	// reset values and writable masks
	// ****************************************
	localparam logic [31:0] RST_GPIO_BASE = 32'h0000_0001;
	localparam logic [7:0] RST_GPIO_CTRL = 8'h00;
	localparam logic [31:0] RST_ROUTE = 32'h8080_8080;
	localparam logic [7:0] RST_SIRQ_CTRL = 8'h10;
	localparam logic [7:0] RST_ERR_CFG = 8'h00;
	localparam logic [7:0] RST_ERR_STS = 8'h00;
	localparam logic [15:0] RST_DMA_SEL = 16'h0000;
	localparam logic [31:0] WMASK_GPIO_BASE = 32'h0000_ffc0;
	localparam logic [31:0] WMASK_GPIO_CTRL = 32'h0000_0010;
	localparam logic [31:0] WMASK_ROUTE = 32'h8f8f_8f8f;
	localparam logic [31:0] WMASK_SIRQ_CTRL = 32'h0000_00ff;
	localparam logic [31:0] WMASK_ERR_CFG = 32'h0000_0006;
	localparam logic [31:0] WMASK_DMA_SEL = 32'h0000_fcff;
	localparam logic [15:0] ROUTE_VALID_MASK = 16'hdef8;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 10;
	localparam int DT_TIMEOUT_NS = 1000000;
	localparam int DT_TIMEOUT_CYCLES = DT_TIMEOUT_NS / CLK_PERIOD_NS;
	localparam logic [5:0] SIRQ_FRAME_BASE = 6'h11;
	localparam logic [1:0] SIRQ_SLOT_LAST_PHASE = 2'h2;
	localparam logic [3:0] SIRQ_PW_00 = 4'h4;
	localparam logic [3:0] SIRQ_PW_01 = 4'h6;
	localparam logic [3:0] SIRQ_PW_10 = 4'h8;
	localparam logic [3:0] SIRQ_STOP_QUIET = 4'h2;
	localparam logic [3:0] SIRQ_STOP_CONT = 4'h3;

	typedef enum logic [1:0] {
		SIRQ_IDLE = 2'b00,
		SIRQ_START = 2'b01,
		SIRQ_SLOT = 2'b10,
		SIRQ_STOP = 2'b11
	} lbidc_sirq_state_type;
endpackage

// ===== rtl/lbidc_route_decode.sv
`timescale 1ns/10ps
`default_nettype none
module lbidc_route_decode (
	// routing code
	input wire logic [3:0] code,
	// one legacy irq per bit
	output logic [15:0] irq_onehot
);
	// reserved codes select nothing
	always_comb begin
		irq_onehot = (16'h0001 << code) & lbidc_pkg::ROUTE_VALID_MASK;
	end
endmodule
`default_nettype wire

// ===== rtl/lbidc_serial_irq.sv
`timescale 1ns/10ps
`default_nettype none
module lbidc_serial_irq (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// control
	input wire logic enable,
	input wire logic continuous,
	input wire logic [3:0] frame_size,
	input wire logic [1:0] pulse_sel,
	// pin
	input wire logic pin_in,
	output logic pin_out,
	output logic pin_oe,
	// sampled slot levels
	output logic [31:0] slots
);
	typedef struct packed {
		lbidc_pkg::lbidc_sirq_state_type state;
		logic [3:0] count;
		logic [4:0] slot;
		logic [1:0] phase;
		logic [31:0] captured;
		logic oe;
		logic [31:0] slots;
	} lbidc_sirq_regs_type;

	lbidc_sirq_regs_type s;
	lbidc_sirq_regs_type next_s;
	logic [3:0] width;
	logic [5:0] frames;

	always_comb begin
		case (pulse_sel)
			2'b00: width = lbidc_pkg::SIRQ_PW_00;
			2'b01: width = lbidc_pkg::SIRQ_PW_01;
			2'b10: width = lbidc_pkg::SIRQ_PW_10;
			default: width = lbidc_pkg::SIRQ_PW_00;
		endcase
		frames = lbidc_pkg::SIRQ_FRAME_BASE + {2'b00, frame_size};
		next_s = s;
		case (s.state)
			lbidc_pkg::SIRQ_IDLE: begin
				next_s.oe = 1'b0;
				if (continuous) begin
					next_s.state = lbidc_pkg::SIRQ_START;
					next_s.count = width;
					next_s.oe = 1'b1;
				end else if (!pin_in) begin
					// peripheral already drove the first low clock
					next_s.state = lbidc_pkg::SIRQ_START;
					next_s.count = width - 4'h1;
					next_s.oe = 1'b1;
				end
			end
			lbidc_pkg::SIRQ_START: begin
				next_s.count = s.count - 4'h1;
				if (s.count == 4'h1) begin
					next_s.oe = 1'b0;
					next_s.state = lbidc_pkg::SIRQ_SLOT;
					next_s.slot = 5'h00;
					next_s.phase = 2'h0;
				end
			end
			lbidc_pkg::SIRQ_SLOT: begin
				if (s.phase == 2'h0) begin
					next_s.captured[s.slot] = pin_in;
				end
				next_s.phase = s.phase + 2'h1;
				if (s.phase == lbidc_pkg::SIRQ_SLOT_LAST_PHASE) begin
					next_s.phase = 2'h0;
					next_s.slot = s.slot + 5'h01;
					if ({1'b0, s.slot} == frames - 6'h01) begin
						next_s.state = lbidc_pkg::SIRQ_STOP;
						next_s.count = continuous ? lbidc_pkg::SIRQ_STOP_CONT : lbidc_pkg::SIRQ_STOP_QUIET;
						next_s.oe = 1'b1;
					end
				end
			end
			lbidc_pkg::SIRQ_STOP: begin
				next_s.count = s.count - 4'h1;
				if (s.count == 4'h1) begin
					next_s.oe = 1'b0;
					next_s.state = lbidc_pkg::SIRQ_IDLE;
					next_s.slots = s.captured;
				end
			end
			default: begin
				next_s.state = lbidc_pkg::SIRQ_IDLE;
				next_s.oe = 1'b0;
			end
		endcase
		// disabled: pin is input only and the stream reads all ones
		if (!enable) begin
			next_s.state = lbidc_pkg::SIRQ_IDLE;
			next_s.oe = 1'b0;
			next_s.captured = '1;
			next_s.slots = '1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			s <= '0;
			s.captured <= '1;
			s.slots <= '1;
		end else begin
			s <= next_s;
		end
	end

	assign pin_out = 1'b0;
	assign pin_oe = s.oe;
	assign slots = s.slots;
endmodule
`default_nettype wire

// ===== dv/lbidc_sirq_peripheral.sv
`timescale 1ns/10ps
`default_nettype none
module lbidc_sirq_peripheral (
	// clock
	input wire logic ref_clk,
	// request from bench and device drive
	input wire logic start_req,
	input wire logic dev_oe,
	input wire logic dev_out,
	// resolved pin level
	output logic pin_level
);
	logic drive_low = 1'b0;

	// one low clock opens a quiet-mode start frame
	always @(posedge ref_clk) begin
		drive_low <= start_req;
	end

	// open drain with external pull-up
	assign pin_level = !(drive_low || (dev_oe && !dev_out));
endmodule
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
	// ****************************************
	// signals
	// ****************************************
	localparam int DT = 20;
	logic ref_clk = 1'b0, reset_n = 1'b0, cfg_wr_en = 1'b0, cfg_rd_en = 1'b0;
	logic [7:0] cfg_addr = 8'h00;
	logic [3:0] cfg_byte_en = 4'h0;
	logic [31:0] cfg_wdata = 32'h0, cfg_rdata, slots, ra, re, base;
	logic cfg_rd_valid, syserr_assert, dt_discard, gpio_decode_hit, gpio_function_enable;
	logic global_syserr_enable = 1'b0, target_abort_evt = 1'b0, dt_complete = 1'b0;
	logic dt_master_return = 1'b0, io_cycle = 1'b0, start_req = 1'b0, pin_level, pin_out, pin_oe;
	logic [15:0] io_addr = 16'h0, legacy_irq, dma_channel_type;
	logic [7:0] irq_line_in = 8'h00;
	int n_fail = 0, checks = 0, seed = 65, len, cnt, found;
	logic [31:0] ofs [8] = '{32'h58, 32'h5c, 32'h60, 32'h64, 32'h68, 32'h88, 32'h90, 32'h70};
	logic [31:0] rst [8] = '{32'h1, 32'h0, 32'h80808080, 32'h10, 32'h80808080, 32'h0, 32'h0, 32'h0};
	logic [31:0] msk [8] = '{32'hffc0, 32'h10, 32'h8f8f8f8f, 32'hff, 32'h8f8f8f8f, 32'h6, 32'hfcff, 32'h0};

	always #5 ref_clk = ~ref_clk;

	lbidc_config #(.DT_TIMEOUT_CYCLES(DT)) uut (.ref_clk(ref_clk), .reset_n(reset_n), .cfg_wr_en(cfg_wr_en),
		.cfg_rd_en(cfg_rd_en), .cfg_addr(cfg_addr), .cfg_byte_en(cfg_byte_en), .cfg_wdata(cfg_wdata),
		.cfg_rdata(cfg_rdata), .cfg_rd_valid(cfg_rd_valid), .global_syserr_enable(global_syserr_enable),
		.target_abort_evt(target_abort_evt), .dt_complete(dt_complete), .dt_master_return(dt_master_return),
		.syserr_assert(syserr_assert), .dt_discard(dt_discard), .io_cycle(io_cycle), .io_addr(io_addr),
		.gpio_decode_hit(gpio_decode_hit), .gpio_function_enable(gpio_function_enable),
		.irq_line_in(irq_line_in), .legacy_irq(legacy_irq), .serial_irq_pin_in(pin_level),
		.serial_irq_pin_out(pin_out), .serial_irq_pin_oe(pin_oe), .serial_irq_slots(slots),
		.dma_channel_type(dma_channel_type));

	lbidc_sirq_peripheral far (.ref_clk(ref_clk), .start_req(start_req), .dev_oe(pin_oe), .dev_out(pin_out),
		.pin_level(pin_level));

	// ****************************************
	// tasks
	// ****************************************
	task tally_and_finish;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic cfg_wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
		cfg_wr_en = 1'b1;
		cfg_addr = a;
		cfg_byte_en = be;
		cfg_wdata = d;
		tick(1);
		cfg_wr_en = 1'b0;
		tick(1);
	endtask

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		cfg_rd_en = 1'b1;
		cfg_addr = a;
		tick(1);
		cfg_rd_en = 1'b0;
		check("cfg_rd_valid", 32'h1, {31'h0, cfg_rd_valid});
		check(what, exp, cfg_rdata);
		tick(1);
	endtask

	task automatic watch(input int n, output int se, output int dd);
		se = 0;
		dd = 0;
		repeat (n) begin
			se += (syserr_assert === 1'b1);
			dd += (dt_discard === 1'b1);
			tick(1);
		end
	endtask

	// kind 0 target abort, 1 unclaimed delayed data, 2 master returns in time
	task automatic err_case(input logic [7:0] cfg, input logic glob, input int kind, input int xse,
		input int xdd, input logic [7:0] xsts);
		int se, dd;
		cfg_wr(8'h88, 4'h1, {24'h0, cfg});
		global_syserr_enable = glob;
		target_abort_evt = (kind == 0);
		dt_complete = (kind != 0);
		tick(1);
		target_abort_evt = 1'b0;
		dt_complete = 1'b0;
		if (kind == 2) begin
			tick(5);
			dt_master_return = 1'b1;
			tick(1);
			dt_master_return = 1'b0;
		end
		watch(DT + 10, se, dd);
		check("syserr pulses", xse, se);
		check("discard pulses", xdd, dd);
		rd_chk("error dword", 8'h88, {8'h0, xsts, 8'h0, cfg});
		cfg_wr(8'h88, 4'h4, 32'h00ff_0000);
	endtask

	task automatic oe_run(output int n);
		int w;
		w = 0;
		n = 0;
		while (pin_oe !== 1'b1) begin
			if (w++ > 300) begin
				n_fail++;
				$display("CHECK FAILED pin_oe expected activity seen none");
				tally_and_finish();
			end
			tick(1);
		end
		while (pin_oe === 1'b1 && n < 20) begin
			n++;
			tick(1);
		end
	endtask

	task automatic oe_count(input int n, output int c);
		c = 0;
		repeat (n) begin
			c += (pin_oe === 1'b1);
			tick(1);
		end
	endtask

	function automatic logic [15:0] exp_legacy(input logic [63:0] r, input logic [7:0] req);
		logic [7:0] b;
		logic [15:0] o;
		o = 16'h0;
		for (int i = 0; i < 8; i++) begin
			b = r[8 * i +: 8];
			if (req[i] && !b[7] && b[3:0] inside {3, 4, 5, 6, 7, 9, 10, 11, 12, 14, 15}) begin
				o[b[3:0]] = 1'b1;
			end
		end
		return o;
	endfunction

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (6) @(posedge ref_clk);
		#1;
		reset_n = 1'b1;
		tick(1);
		check("slots after reset", 32'hffff_ffff, slots);
		for (int i = 0; i < 8; i++) begin
			rd_chk("reset value", ofs[i][7:0], rst[i]);
			ra = $random(seed);
			cfg_wr(ofs[i][7:0], 4'hf, ra);
			rd_chk("written value", ofs[i][7:0], (ra & msk[i]) | (i == 0 ? 32'h1 : 32'h0));
			if (i == 6) check("dma type port", {16'h0, ra[15:0] & 16'hfcff}, {16'h0, dma_channel_type});
		end
		for (int it = 0; it < 40; it++) begin
			ra = (it == 0) ? 32'h8080_8080 : (it == 2) ? 32'h8080_800d : $random(seed);
			re = (it == 1) ? 32'h0f0e_0c09 : $random(seed);
			cfg_wr(8'h60, 4'hf, ra);
			cfg_wr(8'h68, 4'hf, re);
			irq_line_in = (it < 2) ? 8'hff : (it == 2) ? 8'h01 : 8'($random(seed));
			tick(3);
			check("legacy_irq", {16'h0, exp_legacy({re, ra}, irq_line_in)}, {16'h0, legacy_irq});
		end
		base = $random(seed) & 32'hffc0;
		cfg_wr(8'h58, 4'h3, base);
		for (int en = 1; en >= 0; en--) begin
			cfg_wr(8'h5c, 4'h1, en ? 32'h10 : 32'h0);
			check("gpio function", en, {31'h0, gpio_function_enable});
			io_cycle = 1'b1;
			for (int it = 0; it < 16; it++) begin
				io_addr = it[0] ? base[15:0] | 16'($random(seed) & 63) : 16'($random(seed));
				tick(1);
				check("gpio hit", en && io_addr[15:6] == base[15:6], {31'h0, gpio_decode_hit});
			end
			io_cycle = 1'b0;
		end
		err_case(8'h06, 1'b1, 0, 1, 0, 8'h04);
		global_syserr_enable = 1'b1;
		for (int k = 0; k < 2; k++) begin
			tick(2);
			target_abort_evt = 1'b1;
			tick(1);
			target_abort_evt = 1'b0;
		end
		watch(10, cnt, found);
		check("syserr on set status", 0, cnt);
		cfg_wr(8'h88, 4'h4, 32'h0);
		rd_chk("status after zero write", 8'h88, 32'h0004_0006);
		cfg_wr(8'h88, 4'h4, 32'h0004_0000);
		rd_chk("status after clear", 8'h88, 32'h0000_0006);
		err_case(8'h02, 1'b1, 0, 0, 0, 8'h04);
		err_case(8'h06, 1'b0, 0, 0, 0, 8'h04);
		err_case(8'h04, 1'b1, 1, 0, 1, 8'h02);
		err_case(8'h02, 1'b1, 2, 0, 0, 8'h00);
		err_case(8'h02, 1'b1, 1, 1, 1, 8'h02);
		err_case(8'h02, 1'b0, 1, 0, 1, 8'h02);
		for (int p = 0; p < 3; p++) begin
			cfg_wr(8'h64, 4'h1, 32'hd0 | p);
			found = 0;
			for (int k = 0; k < 10 && found < 2; k++) begin
				oe_run(len);
				found += (len != 3);
			end
			check("continuous start width", 4 + 2 * p, len);
		end
		for (int p = 0; p < 3; p++) begin
			cfg_wr(8'h64, 4'h1, 32'h90 | p);
			tick(150);
			start_req = 1'b1;
			tick(1);
			start_req = 1'b0;
			oe_run(len);
			check("quiet start width", 3 + 2 * p, len);
		end
		tick(150);
		oe_count(200, cnt);
		check("quiet idle drive", 0, cnt);
		cfg_wr(8'h64, 4'h1, 32'h50);
		tick(150);
		oe_count(200, cnt);
		check("disabled drive", 0, cnt);
		check("disabled slots", 32'hffff_ffff, slots);
		check("pin_out", 32'h0, {31'h0, pin_out});
		tally_and_finish();
	end
endmodule
`default_nettype wire
